// >>> hdl/fcl_pkg.sv
// Purpose: Constants and types for the flash command, ready and protection block
// Assumes: 16-bit word commands; low 12 word-address bits form the command offset
// Notes:
// Functional notes
// R1: Erase suspend is one write of 00B0h
// R2: Erase resume 0030h continues suspended sector erase
// R3: Host limits accelerated operations to 50 per sector
// R4: Host avoids simultaneous operations at high voltage
// R5: Host waits 100 ms before accelerated erase
// R6: Ready driven when any chip enable low
// R7: Data bus driven only on enable plus OE
// R8: First burst word only after ready rises
// R9: Ready timing bit selects same or earlier cycle
// R10: Asynchronous mode holds ready high while enabled
// R11: Held reset pin aborts, tristates, clears config
// R12: Host reissues operation interrupted by reset
// R13: Write of 00F0h returns device to idle
// R14: Software reset ignored during program or erase
// R15: All sectors unlocked after power-up
// R16: Lock sequence AAA/555 with 60h, then sector
// R17: At most one sector unlocked after locking
// R18: Low lock select bit locks every sector
// R19: Unlock checked only at operation start
// R20: Resume does not check the unlocked sector
// R21: Unlock aimed at range sector locks all
// R22: Suspend accepted only during sector erase
// R23: Suspended sector reads return undefined data
// R24: Range-protected sector stays locked regardless
// R25: Bad lock sequence write abandons, state unchanged

package fcl_pkg;
    localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
    localparam logic [15:0] CMD_RESUME = 16'h0030;
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [15:0] CMD_LOCK = 16'h0060;
    localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
    localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
    localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
    localparam logic [11:0] LOCK_OFS1 = 12'haaa;
    localparam logic [11:0] LOCK_OFS2 = 12'h555;
    localparam int LOCK_SEL_BIT = 6;
    localparam logic [15:0] SUSP_READ_DATA = 16'h0000;
    localparam int CLK_PERIOD_NS = 40;
    // APB map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam int CTRL_RDY_TIMING = 0;
    localparam int CTRL_SYNC_MODE = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int STS_BUSY = 0;
    localparam int STS_SUSP = 1;
    localparam int STS_LOCK_MODE = 2;
    localparam int STS_UNLK_VALID = 3;
    localparam int STS_UNLK_LSB = 8;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LK1, ST_LK2, ST_ERS_SETUP, ST_PRG_SETUP,
        ST_SECT_ERASE, ST_CHIP_ERASE, ST_SUSP
    } fcl_state_t;
    typedef enum logic {OP_NONE, OP_PROGRAM} fcl_sub_t;
endpackage : fcl_pkg

// >>> hdl/fcl_ctrl.sv
// Purpose: Command decode, ready/data pin control, reset and sector lock state
// Assumes: Flash pins and burst clock asynchronous to i_sys_clk; array data local
// Notes: Embedded algorithms modelled as fixed cycle counts
//
// Design decisions made here: the APB register port and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module fcl_ctrl #(
    parameter int ADDR_W = 24,
    parameter int SECT_W = 8,
    parameter int BANK_W = 4,
    parameter int OP_CYCLES = 64,
    parameter int BURST_LATENCY = 4,
    parameter int RESET_PULSE_NS = 200
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Flash pins
    input wire logic i_ce1_n,
    input wire logic i_ce2_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_reset_n,
    input wire logic i_burst_clk,
    input wire logic i_accel_voltage_pin,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_data_bus,
    output logic [15:0] o_data_bus,
    output logic o_data_bus_oe,
    output logic o_rdy,
    output logic o_rdy_oe,
    // Array data and range protection
    input wire logic [15:0] i_array_rdata,
    input wire logic i_range_valid,
    input wire logic [SECT_W-1:0] i_range_lo,
    input wire logic [SECT_W-1:0] i_range_hi,
    output logic o_busy,
    // APB
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);
    import fcl_pkg::*;

    localparam int PIN_W = 7 + ADDR_W + 16;
    localparam int RST_CYC_RAW = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
    localparam logic [15:0] OP_CNT = 16'(OP_CYCLES);
    localparam logic [7:0] LAT = 8'(BURST_LATENCY);
    localparam logic [7:0] RST_CNT = 8'(RST_CYC);

    if (SECT_W < BANK_W || SECT_W > ADDR_W - 12 || OP_CYCLES < 2 || OP_CYCLES > 65535 ||
        BURST_LATENCY < 2 || BURST_LATENCY > 254 || RST_CYC > 254) begin : g_chk
        $error("fcl_ctrl: unsupported parameter values");
    end

    function automatic logic [SECT_W-1:0] sect_of(input logic [ADDR_W-1:0] a);
        sect_of = a[ADDR_W-1 -: SECT_W];
    endfunction : sect_of

    function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
        bank_of = a[ADDR_W-1 -: BANK_W];
    endfunction : bank_of

    // Two-flop synchronisers for every pin
    logic [PIN_W-1:0] sync1_ff;
    logic [PIN_W-1:0] sync2_ff;
    logic we_prev_ff;
    logic bclk_prev_ff;
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
            we_prev_ff <= 1'b1;
            bclk_prev_ff <= 1'b1;
        end else begin
            sync1_ff <= {i_ce1_n, i_ce2_n, i_oe_n, i_we_n, i_reset_n, i_burst_clk,
                         i_accel_voltage_pin, i_addr, i_data_bus};
            sync2_ff <= sync1_ff;
            we_prev_ff <= sync2_ff[PIN_W-4];
            bclk_prev_ff <= sync2_ff[PIN_W-6];
        end
    end

    wire ce1_n_s = sync2_ff[PIN_W-1];
    wire ce2_n_s = sync2_ff[PIN_W-2];
    wire oe_n_s = sync2_ff[PIN_W-3];
    wire we_n_s = sync2_ff[PIN_W-4];
    wire rst_n_s = sync2_ff[PIN_W-5];
    wire bclk_s = sync2_ff[PIN_W-6];
    // Accelerated-voltage pin is only observed; its usage limits are the host's job
    wire accel_s = sync2_ff[PIN_W-7];
    wire [ADDR_W-1:0] addr_s = sync2_ff[16 +: ADDR_W];
    wire [15:0] wdata_s = sync2_ff[15:0];

    // Hardware reset pin: abort only once held for the minimum pulse
    logic [7:0] rst_cnt_ff;
    wire in_rst = !rst_n_s && (rst_cnt_ff >= RST_CNT);
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || rst_n_s) rst_cnt_ff <= 8'h00;
        else if (!in_rst) rst_cnt_ff <= rst_cnt_ff + 8'h01;
    end

    wire ce_act = !ce1_n_s || !ce2_n_s;
    // Writes ignored while reset pin is low at all
    wire wr_evt = we_n_s && !we_prev_ff && ce_act && oe_n_s && rst_n_s; // R11
    wire [11:0] ofs = addr_s[11:0];
    wire [SECT_W-1:0] wsect = sect_of(addr_s);
    wire lock_sel = addr_s[LOCK_SEL_BIT];

    // Command and protection state
    fcl_state_t state_ff, nxt_state;
    fcl_sub_t sub_ff, nxt_sub;
    logic lock_mode_ff, nxt_lock_mode;
    logic unlk_valid_ff, nxt_unlk_valid;
    logic [SECT_W-1:0] unlk_sect_ff, nxt_unlk_sect;
    logic [SECT_W-1:0] ers_sect_ff, nxt_ers_sect;
    logic [15:0] ers_cnt_ff, nxt_ers_cnt;
    logic [15:0] prg_cnt_ff, nxt_prg_cnt;

    wire in_range = i_range_valid && wsect >= i_range_lo && wsect <= i_range_hi;
    wire sect_ok = !in_range && (!lock_mode_ff || // R24
                   (unlk_valid_ff && unlk_sect_ff == wsect)); // R19
    wire chip_ok = !i_range_valid && (!lock_mode_ff ||
                   (unlk_valid_ff && unlk_sect_ff == '0));
    wire bank_hit = bank_of(addr_s) == ers_sect_ff[SECT_W-1 -: BANK_W];
    wire susp_view = state_ff == ST_SUSP || (sub_ff == OP_PROGRAM && state_ff != ST_IDLE &&
                     ers_cnt_ff != 16'h0000);

    always_comb begin
        nxt_state = state_ff;
        nxt_sub = sub_ff;
        nxt_lock_mode = lock_mode_ff;
        nxt_unlk_valid = unlk_valid_ff;
        nxt_unlk_sect = unlk_sect_ff;
        nxt_ers_sect = ers_sect_ff;
        nxt_ers_cnt = ers_cnt_ff;
        nxt_prg_cnt = prg_cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                // Any other word, 00F0h included, leaves the device idle
                if (wr_evt && wdata_s == CMD_LOCK && ofs == LOCK_OFS1) nxt_state = ST_LK1; // R16
                else if (wr_evt && wdata_s == CMD_ERASE_SETUP) nxt_state = ST_ERS_SETUP;
                else if (wr_evt && wdata_s == CMD_PROGRAM) nxt_state = ST_PRG_SETUP;
            end
            ST_LK1: begin
                if (wr_evt && wdata_s == CMD_LOCK && ofs == LOCK_OFS2) nxt_state = ST_LK2; // R16
                else if (wr_evt) nxt_state = ST_IDLE; // R25 R13
            end
            ST_LK2: begin
                if (wr_evt) begin
                    nxt_state = ST_IDLE; // R25 R13
                    if (wdata_s == CMD_LOCK) begin
                        nxt_lock_mode = 1'b1;
                        if (!lock_sel || in_range) begin
                            nxt_unlk_valid = 1'b0; // R18 R21
                        end else begin
                            // Single slot: a new unlock relocks the previous one
                            nxt_unlk_valid = 1'b1; // R17
                            nxt_unlk_sect = wsect;
                        end
                    end
                end
            end
            ST_ERS_SETUP: begin
                if (wr_evt) begin
                    nxt_state = ST_IDLE; // R13
                    if (wdata_s == CMD_RESUME && sect_ok) begin
                        nxt_state = ST_SECT_ERASE; // R19
                        nxt_ers_sect = wsect;
                        nxt_ers_cnt = OP_CNT;
                    end else if (wdata_s == CMD_CHIP_ERASE && chip_ok) begin
                        nxt_state = ST_CHIP_ERASE;
                        nxt_ers_cnt = OP_CNT;
                    end
                end
            end
            ST_PRG_SETUP: begin
                if (wr_evt) begin
                    nxt_state = (ers_cnt_ff != 16'h0000) ? ST_SUSP : ST_IDLE;
                    if (sect_ok && !(ers_cnt_ff != 16'h0000 && wsect == ers_sect_ff)) begin
                        nxt_state = ST_CHIP_ERASE;
                        nxt_sub = OP_PROGRAM; // R19
                        nxt_prg_cnt = OP_CNT;
                    end
                end
            end
            ST_SECT_ERASE: begin
                nxt_ers_cnt = ers_cnt_ff - 16'h0001;
                if (ers_cnt_ff == 16'h0001) nxt_state = ST_IDLE;
                else if (wr_evt && wdata_s == CMD_SUSPEND && bank_hit) nxt_state = ST_SUSP; // R1
            end
            ST_CHIP_ERASE: begin
                // Shared busy state: chip erase or program; all writes ignored here
                if (sub_ff == OP_PROGRAM) begin // R14 R22
                    nxt_prg_cnt = prg_cnt_ff - 16'h0001;
                    if (prg_cnt_ff == 16'h0001) begin
                        nxt_sub = OP_NONE;
                        nxt_state = (ers_cnt_ff != 16'h0000) ? ST_SUSP : ST_IDLE;
                    end
                end else begin
                    nxt_ers_cnt = ers_cnt_ff - 16'h0001;
                    if (ers_cnt_ff == 16'h0001) nxt_state = ST_IDLE;
                end
            end
            ST_SUSP: begin
                // No unlock check on resume; software reset ignored here too
                if (wr_evt && wdata_s == CMD_RESUME && bank_hit) nxt_state = ST_SECT_ERASE; // R2 R20 R14
                else if (wr_evt && wdata_s == CMD_PROGRAM) nxt_state = ST_PRG_SETUP;
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (in_rst) begin
            nxt_state = ST_IDLE; // R11
            nxt_sub = OP_NONE;
            nxt_ers_cnt = 16'h0000;
            nxt_prg_cnt = 16'h0000;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_ff <= ST_IDLE;
            sub_ff <= OP_NONE;
            lock_mode_ff <= 1'b0; // R15
            unlk_valid_ff <= 1'b0;
            unlk_sect_ff <= '0;
            ers_sect_ff <= '0;
            ers_cnt_ff <= 16'h0000;
            prg_cnt_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            sub_ff <= nxt_sub;
            lock_mode_ff <= nxt_lock_mode;
            unlk_valid_ff <= nxt_unlk_valid;
            unlk_sect_ff <= nxt_unlk_sect;
            ers_sect_ff <= nxt_ers_sect;
            ers_cnt_ff <= nxt_ers_cnt;
            prg_cnt_ff <= nxt_prg_cnt;
        end
    end

    // Read path and ready handshake
    logic [1:0] ctrl_ff;
    logic [7:0] lat_cnt_ff;
    wire sync_mode = ctrl_ff[CTRL_SYNC_MODE];
    wire rd_act = ce_act && !oe_n_s && !in_rst;
    wire bclk_rise = bclk_s && !bclk_prev_ff;
    wire word_valid = lat_cnt_ff >= LAT;
    wire rdy_early = lat_cnt_ff >= LAT - 8'h01;
    wire nxt_rdy = !sync_mode ? 1'b1 : // R10
                   (ctrl_ff[CTRL_RDY_TIMING] ? rdy_early : word_valid); // R9
    wire [15:0] arr_word = (susp_view && sect_of(addr_s) == ers_sect_ff) ?
                           SUSP_READ_DATA : i_array_rdata; // R23
    wire [15:0] nxt_data = (sync_mode && !word_valid) ? 16'h0000 : arr_word; // R8

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !rd_act) lat_cnt_ff <= 8'h00;
        else if (bclk_rise && lat_cnt_ff != 8'hff) lat_cnt_ff <= lat_cnt_ff + 8'h01;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_data_bus <= 16'h0000;
            o_data_bus_oe <= 1'b0;
            o_rdy <= 1'b0;
            o_rdy_oe <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_data_bus <= rd_act ? nxt_data : 16'h0000;
            o_data_bus_oe <= rd_act; // R7 R11
            o_rdy <= ce_act && !in_rst && nxt_rdy;
            o_rdy_oe <= ce_act && !in_rst; // R6 R11
            o_busy <= nxt_state == ST_SECT_ERASE || nxt_state == ST_CHIP_ERASE;
        end
    end

    // APB slave: one wait state, registered answer
    wire apb_acc = i_psel && i_penable && !o_pready;
    wire hit_ctrl = i_paddr == REG_CTRL;
    wire hit_sts = i_paddr == REG_STATUS;
    wire [31:0] sts_word = 32'(unlk_sect_ff) << STS_UNLK_LSB |
                           32'(unlk_valid_ff) << STS_UNLK_VALID |
                           32'(lock_mode_ff) << STS_LOCK_MODE |
                           32'(susp_view) << STS_SUSP |
                           32'(o_busy) << STS_BUSY |
                           32'(accel_s) << 31;
    wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl_ff) : (hit_sts ? sts_word : 32'h0000_0000);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctrl_ff <= CTRL_RESET;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_pready <= apb_acc;
            o_pslverr <= apb_acc && !hit_ctrl && !hit_sts;
            o_prdata <= (apb_acc && !i_pwrite) ? rd_mux : 32'h0000_0000;
            if (in_rst) ctrl_ff <= CTRL_RESET; // R11
            else if (apb_acc && i_pwrite && hit_ctrl) ctrl_ff <= i_pwdata[1:0];
        end
    end

    property p_rdy_drive;
        @(posedge i_sys_clk) disable iff (i_srst) (ce_act && !in_rst) |=> o_rdy_oe;
    endproperty
    a_rdy_drive: assert property (p_rdy_drive) else $error("ready not driven"); // R6
    property p_data_float;
        @(posedge i_sys_clk) disable iff (i_srst) (!ce_act || oe_n_s) |=> !o_data_bus_oe;
    endproperty
    a_data_float: assert property (p_data_float) else $error("data bus driven"); // R7
    property p_async_rdy;
        @(posedge i_sys_clk) disable iff (i_srst)
            (!sync_mode && ce_act && !in_rst) |=> o_rdy;
    endproperty
    a_async_rdy: assert property (p_async_rdy) else $error("async ready low"); // R10
    property p_burst_hold;
        @(posedge i_sys_clk) disable iff (i_srst)
            (rd_act && sync_mode && !word_valid) |=> (o_data_bus == 16'h0000);
    endproperty
    a_burst_hold: assert property (p_burst_hold) else $error("early burst word"); // R8
    property p_hw_reset;
        @(posedge i_sys_clk) disable iff (i_srst)
            in_rst |=> (state_ff == ST_IDLE && !o_rdy_oe && !o_data_bus_oe && ctrl_ff == 2'h0);
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("reset not applied"); // R11
    property p_suspend;
        @(posedge i_sys_clk) disable iff (i_srst)
            (state_ff == ST_SECT_ERASE && wr_evt && wdata_s == CMD_SUSPEND && bank_hit &&
             ers_cnt_ff > 16'h0001 && !in_rst) |=> state_ff == ST_SUSP;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend missed"); // R1
    property p_chip_nosusp;
        @(posedge i_sys_clk) disable iff (i_srst)
            (state_ff == ST_CHIP_ERASE && sub_ff == OP_NONE && wr_evt) |=> state_ff != ST_SUSP;
    endproperty
    a_chip_nosusp: assert property (p_chip_nosusp) else $error("chip erase suspended"); // R22
    property p_swrst_ignored;
        @(posedge i_sys_clk) disable iff (i_srst)
            (state_ff == ST_SECT_ERASE && wr_evt && wdata_s == CMD_RESET &&
             ers_cnt_ff > 16'h0001 && !in_rst) |=> state_ff == ST_SECT_ERASE;
    endproperty
    a_swrst_ignored: assert property (p_swrst_ignored) else $error("reset cut erase"); // R14
    property p_lock_all;
        @(posedge i_sys_clk) disable iff (i_srst)
            (state_ff == ST_LK2 && wr_evt && wdata_s == CMD_LOCK && !lock_sel && !in_rst)
            |=> (lock_mode_ff && !unlk_valid_ff);
    endproperty
    a_lock_all: assert property (p_lock_all) else $error("lock all failed"); // R18
    property p_bad_seq;
        @(posedge i_sys_clk) disable iff (i_srst)
            (state_ff == ST_LK1 && wr_evt && wdata_s != CMD_LOCK)
            |=> (state_ff == ST_IDLE && $stable(lock_mode_ff) && $stable(unlk_valid_ff));
    endproperty
    a_bad_seq: assert property (p_bad_seq) else $error("bad sequence kept"); // R25
endmodule : fcl_ctrl

`default_nettype wire

// >>> dv/fcl_host_model.sv
// Purpose: Host memory controller model driving the flash pins
// Assumes: Pins other than the burst clock change by non-blocking assignment after i_clk rising edges
// Notes: Burst clock starts only inside frames, finishes the period it is in after a frame ends, then stands low
`timescale 1ns/1ps
`default_nettype none
module fcl_host_model (
    // Clock
    input wire logic i_clk,
    // Flash pins
    output logic o_ce1_n = 1'b1,
    output logic o_ce2_n = 1'b1,
    output logic o_oe_n = 1'b1,
    output logic o_we_n = 1'b1,
    output logic o_reset_n = 1'b1,
    output logic o_burst_clk = 1'b0,
    output logic o_accel = 1'b0,
    output logic [23:0] o_addr = 24'h0,
    output logic [15:0] o_data = 16'h0
);
    logic burst_run = 1'b0;
    // Odd phase keeps burst edges off the system clock edges
    always begin
        wait (burst_run);
        #153 o_burst_clk = 1'b1;
        #160 o_burst_clk = 1'b0;
        #7;
    end
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        o_addr <= a;
        o_data <= d;
        o_ce1_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_we_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        o_we_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_ce1_n <= 1'b1;
        // Released bus must not keep showing the old word
        o_data <= ~d;
        @(posedge i_clk);
    endtask : wr
    task automatic pins(input logic rst_n, input logic acc);
        o_reset_n <= rst_n;
        o_accel <= acc;
        @(posedge i_clk);
    endtask : pins
    task automatic frame(input logic ce_n, input logic oe_n, input logic burst);
        o_ce2_n <= ce_n;
        o_oe_n <= oe_n;
        burst_run <= burst;
        @(posedge i_clk);
    endtask : frame
endmodule : fcl_host_model
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the flash command and protection block
// Assumes: APB slave answers one cycle after the access edge
// Notes: Erase length left at its default so suspend lands mid-erase
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fcl_pkg::*;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic rvalid = 1'b0, rerr, o_rdy, o_rdy_oe, o_data_bus_oe, o_busy, o_pready, o_pslverr;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rdat, o_prdata;
    logic [7:0] rlo = 8'h02, rhi = 8'h03;
    logic [15:0] o_data_bus;
    wire ce1_n, ce2_n, oe_n, we_n, rst_n, bclk, accel;
    wire [23:0] addr;
    wire [15:0] wdat;
    int fails = 0, tests_run = 0, cycles = 0, n;
    int lat [2];
    always #20 clk = ~clk;
    fcl_host_model u_host (.i_clk(clk), .o_ce1_n(ce1_n), .o_ce2_n(ce2_n), .o_oe_n(oe_n),
        .o_we_n(we_n), .o_reset_n(rst_n), .o_burst_clk(bclk), .o_accel(accel),
        .o_addr(addr), .o_data(wdat));
    fcl_ctrl u_dut (.i_sys_clk(clk), .i_srst(srst), .i_ce1_n(ce1_n), .i_ce2_n(ce2_n),
        .i_oe_n(oe_n), .i_we_n(we_n), .i_reset_n(rst_n), .i_burst_clk(bclk),
        .i_accel_voltage_pin(accel), .i_addr(addr), .i_data_bus(wdat),
        .o_data_bus(o_data_bus), .o_data_bus_oe(o_data_bus_oe), .o_rdy(o_rdy),
        .o_rdy_oe(o_rdy_oe), .i_array_rdata(16'h1234), .i_range_valid(rvalid),
        .i_range_lo(rlo), .i_range_hi(rhi), .o_busy(o_busy), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Only the cycle ceiling ends a wait for the answer
        do begin
            @(posedge clk);
        end while (o_pready !== 1'b1);
        rdat = o_prdata;
        rerr = o_pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rdat & m, e);
    endtask : st
    task automatic lock(input logic [7:0] s, input logic sel);
        u_host.wr({12'h0, LOCK_OFS1}, CMD_LOCK);
        u_host.wr({12'h0, LOCK_OFS2}, CMD_LOCK);
        u_host.wr({s, 9'h0, sel, 6'h0}, CMD_LOCK);
    endtask : lock
    task automatic idle_wait();
        n = 0;
        while (o_busy !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, o_busy}, 32'h0);
    endtask : idle_wait
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rdat, 32'h0);
        st(32'h0000000f, 32'h0);
        u_host.pins(1'b1, 1'b1);
        repeat (3) @(posedge clk);
        st(32'h8000_0000, 32'h8000_0000);
        u_host.pins(1'b1, 1'b0);
        apb(1'b1, 12'h008, 32'h3);
        chk({31'h0, rerr}, 32'h1);
        u_host.frame(1'b0, 1'b0, 1'b0);
        repeat (5) @(posedge clk);
        chk({13'h0, o_rdy_oe, o_rdy, o_data_bus_oe, o_data_bus}, 32'h71234);
        u_host.frame(1'b0, 1'b1, 1'b0);
        repeat (5) @(posedge clk);
        chk({30'h0, o_rdy_oe, o_data_bus_oe}, 32'h2);
        u_host.frame(1'b1, 1'b1, 1'b0);
        repeat (5) @(posedge clk);
        chk({31'h0, o_rdy_oe}, 32'h0);
        lock(8'h05, 1'b1);
        st(32'h0000ff0c, 32'h0000050c);
        u_host.wr({12'h0, LOCK_OFS1}, CMD_LOCK);
        u_host.wr({12'h0, LOCK_OFS2}, 16'h0061);
        u_host.wr(24'h070040, CMD_LOCK);
        st(32'h0000ff0c, 32'h0000050c);
        u_host.wr({12'h0, LOCK_OFS1}, CMD_LOCK);
        u_host.wr(24'h0, CMD_RESET);
        u_host.wr({12'h0, LOCK_OFS2}, CMD_LOCK);
        u_host.wr(24'h050000, CMD_LOCK);
        st(32'h0000ff0c, 32'h0000050c);
        u_host.wr(24'h0, CMD_ERASE_SETUP);
        u_host.wr(24'h050000, CMD_RESUME);
        st(32'h3, 32'h1);
        u_host.wr(24'h0, CMD_RESET);
        st(32'h3, 32'h1);
        u_host.wr(24'h050000, CMD_SUSPEND);
        st(32'h2, 32'h2);
        u_host.frame(1'b0, 1'b0, 1'b0);
        repeat (5) @(posedge clk);
        chk({16'h0, o_data_bus}, {16'h0, SUSP_READ_DATA});
        u_host.frame(1'b1, 1'b1, 1'b0);
        u_host.wr(24'h050000, CMD_RESUME);
        st(32'h3, 32'h1);
        idle_wait();
        lock(8'h00, 1'b1);
        u_host.wr(24'h0, CMD_ERASE_SETUP);
        u_host.wr(24'h0, CMD_CHIP_ERASE);
        u_host.wr(24'h0, CMD_SUSPEND);
        st(32'h3, 32'h1);
        idle_wait();
        u_host.wr(24'h0, CMD_PROGRAM);
        u_host.wr(24'h000100, 16'h5555);
        st(32'h3, 32'h1);
        idle_wait();
        u_host.wr(24'h0, CMD_PROGRAM);
        u_host.wr(24'h050100, 16'h5555);
        st(32'h1, 32'h0);
        lock(8'h00, 1'b0);
        st(32'h0000000c, 32'h4);
        rvalid <= 1'b1;
        lock(8'h09, 1'b1);
        lock(8'h02, 1'b1);
        st(32'h0000000c, 32'h4);
        rvalid <= 1'b0;
        for (int b = 0; b < 2; b++) begin
            apb(1'b1, REG_CTRL, {30'h0, 1'b1, b[0]});
            u_host.frame(1'b0, 1'b0, 1'b1);
            n = 0;
            while (o_rdy !== 1'b1 && n < 300) begin
                if (b == 0) chk({16'h0, o_data_bus}, 32'h0);
                @(posedge clk);
                n++;
            end
            lat[b] = n;
            u_host.frame(1'b1, 1'b1, 1'b0);
            repeat (12) @(posedge clk);
        end
        chk((lat[0] - lat[1] inside {[6:10]}) ? 32'h1 : 32'h0, 32'h1);
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rdat, 32'h3);
        u_host.frame(1'b0, 1'b0, 1'b0);
        u_host.pins(1'b0, 1'b0);
        repeat (12) @(posedge clk);
        chk({30'h0, o_rdy_oe, o_data_bus_oe}, 32'h0);
        u_host.pins(1'b1, 1'b0);
        u_host.frame(1'b1, 1'b1, 1'b0);
        repeat (5) @(posedge clk);
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rdat, 32'h0);
        lock(8'h05, 1'b1);
        st(32'h0000ff0c, 32'h0000050c);
        // Reset pin cuts a running erase; host then reissues it
        u_host.wr(24'h0, CMD_ERASE_SETUP);
        u_host.wr(24'h050000, CMD_RESUME);
        u_host.pins(1'b0, 1'b0);
        repeat (12) @(posedge clk);
        st(32'h1, 32'h0);
        u_host.pins(1'b1, 1'b0);
        repeat (5) @(posedge clk);
        u_host.wr(24'h0, CMD_ERASE_SETUP);
        u_host.wr(24'h050000, CMD_RESUME);
        st(32'h1, 32'h1);
        idle_wait();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
